// ==== hw/fom_pkg.sv ====
// package: address map, request and answer carriers for the flash space map
package fom_pkg;

  // ---------------------------------------------------------------
  // address layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int ARRAY_AW = 21;
  localparam int BLK_LSB = 16;
  localparam int BLK_W = 5;
  localparam int SECT_LSB = 12;
  localparam int SECT_W = 9;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_W = 13;
  localparam int SREG_SEL_LSB = 12;
  localparam int SREG_SEL_W = 2;
  localparam int SREG_GAP_LSB = 8;
  localparam int SREG_TOP_LSB = 14;
  localparam int SREG_BYTE_W = 8;
  localparam int MEM_AW = SREG_SEL_W + SREG_BYTE_W;
  localparam int NUM_LOCKS = 3;

  // ---------------------------------------------------------------
  // parameter space map
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_PARAM_READ = 8'h5A;
  localparam logic [7:0] PSP_SIG_BASE = 8'h00;
  localparam logic [7:0] PSP_HDR_EXT = 8'h10;
  localparam logic [7:0] PSP_TBL_BASE = 8'h30;
  localparam logic [7:0] PSP_END = 8'h6F;
  localparam logic [31:0] PSP_SIG = 32'h5044_4653;
  localparam int PSP_SIG_N = 4;
  localparam int PSP_HDR_N = 12;
  localparam int PSP_TBL_N = 64;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] ZERO_B = 8'h00;
  localparam logic [7:0] LAST_IDX = 8'hFF;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    FOM_OP_ARRAY_READ, FOM_OP_PROGRAM, FOM_OP_ERASE_PAGE,
    FOM_OP_ERASE_SECTOR, FOM_OP_ERASE_BLOCK, FOM_OP_ERASE_CHIP,
    FOM_OP_SEC_READ, FOM_OP_SEC_PROGRAM, FOM_OP_SEC_ERASE, FOM_OP_SEC_LOCK
  } fom_op_t;

  typedef enum logic [2:0] {
    FOM_ARR_READ, FOM_ARR_PROG, FOM_ARR_ERASE_SECTOR,
    FOM_ARR_ERASE_BLOCK, FOM_ARR_ERASE_CHIP
  } fom_arr_kind_t;

  typedef struct packed {
    logic valid;
    fom_op_t op;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] old_data;
  } fom_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [7:0] rdata;
  } fom_resp_t;

  typedef struct packed {
    logic go;
    fom_arr_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [BLK_W-1:0] block;
    logic [SECT_W-1:0] sector;
    logic [PAGE_W-1:0] page;
    logic [7:0] wdata;
  } fom_arr_t;

  function automatic logic fom_is_sec(input fom_op_t op);
    return op inside {FOM_OP_SEC_READ, FOM_OP_SEC_PROGRAM,
                      FOM_OP_SEC_ERASE, FOM_OP_SEC_LOCK};
  endfunction : fom_is_sec

endpackage : fom_pkg

// ==== hw/fom_otp_mem.sv ====
// security register storage, 4 x 256 bytes, registered read
`timescale 1ns/1ps
module fom_otp_mem
  import fom_pkg::*;
(
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [MEM_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem [0:(1<<MEM_AW)-1];

  // no reset: contents stand for cells, blank state is not modelled
  always_ff @(posedge clk_i) begin
    if (en_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (en_i && !we_i) begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule : fom_otp_mem

// ==== hw/fom_space_map.sv ====
// flash array and security space map: decode, granularity, lock guard
// ---------------------------------------------------------------
// Overview of operation
// [R1] program only clears bits, never sets
// [R2] erase by sector, block, chip; page erase refused
// [R3] 32 blocks of 64K, block from bits 20:16
// [R4] 512 sectors of 4K, aligned base
// [R5] 256-byte pages are the program unit
// [R6] four 256-byte registers at n x 1000h
// [R7] set lock bit blocks register changes forever; here reset clears any lock bit that lock_nv_i does not hold
// [R8] registers 1-3 erase, program, lock independently
// [R9] opcode 5Ah reads parameter space, not array
// [R10] parameter space refuses program and erase
// [R11] header begins at byte 0000h
// [R12] bytes 0010h up to table undefined
// [R13] basic table starts at byte 0030h
// [R14] space ends 006Fh, 0070h-00FFh reserved
// [R15] byte 00h holds ASCII S
// [R16] undefined or reserved bytes read FFh
// ---------------------------------------------------------------
`timescale 1ns/1ps
module fom_space_map
  import fom_pkg::*;
#(
  parameter logic [8*PSP_HDR_N-1:0] HDR_P = '1,
  parameter logic [8*PSP_TBL_N-1:0] TBL_P = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire fom_req_t req_i,
  input wire logic [NUM_LOCKS-1:0] lock_nv_i,
  output logic ready_o,
  output fom_resp_t resp_o,
  output fom_arr_t arr_o,
  output logic [NUM_LOCKS-1:0] lock_o
);

  // ---------------------------------------------------------------
  // parameter space image
  // ---------------------------------------------------------------
  function automatic logic [7:0] psp_byte(input logic [ADDR_W-1:0] a);
    int i;
    i = int'(a[SREG_BYTE_W-1:0]);
    if (|a[ADDR_W-1:SREG_BYTE_W]) begin
      return ERASED; // R16
    end else if (i < PSP_SIG_N) begin
      return PSP_SIG[8*i+:8]; // R11 R15
    end else if (a[7:0] < PSP_HDR_EXT) begin
      return HDR_P[8*(i-PSP_SIG_N)+:8];
    end else if (a[7:0] < PSP_TBL_BASE) begin
      return ERASED; // R12
    end else if (a[7:0] <= PSP_END) begin
      return TBL_P[8*(i-int'(PSP_TBL_BASE))+:8]; // R13
    end else begin
      return ERASED; // R14
    end
  endfunction : psp_byte

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ERASE} fom_state_t;

  fom_state_t state_q, state_d;
  fom_op_t op_q;
  logic err_q, param_q, taken;
  logic [7:0] prd_q, wdata_q, cnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic [SREG_SEL_W-1:0] sel_q, sel;
  logic [NUM_LOCKS-1:0] lock_q;
  logic [NUM_LOCKS:0] lock_all;
  logic is_param, arr_bad, sec_bad, locked, err_d;
  logic mem_en, mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;

  // ready_o stays low one cycle after reset, so the lock copy refills first
  assign taken = (state_q == S_IDLE) && ready_o && req_i.valid;
  assign is_param = req_i.opcode == CMD_PARAM_READ; // R9
  assign sel = req_i.addr[SREG_SEL_LSB+:SREG_SEL_W];
  assign arr_bad = |req_i.addr[ADDR_W-1:ARRAY_AW]; // R3
  // window is n x 1000h to +0FFh; gap bits and high bits must be clear
  assign sec_bad = |req_i.addr[ADDR_W-1:SREG_TOP_LSB] ||
                   |req_i.addr[SREG_SEL_LSB-1:SREG_GAP_LSB]; // R6
  // register 0 reads as permanently locked: factory content
  assign lock_all = {lock_q, 1'b1}; // R10
  assign locked = lock_all[sel]; // R7 R8

  always_comb begin
    err_d = 1'b0;
    if (!is_param) begin
      case (req_i.op)
        FOM_OP_ARRAY_READ, FOM_OP_PROGRAM, FOM_OP_ERASE_SECTOR,
        FOM_OP_ERASE_BLOCK: err_d = arr_bad;
        FOM_OP_ERASE_PAGE: err_d = 1'b1; // R2
        FOM_OP_ERASE_CHIP: err_d = 1'b0;
        FOM_OP_SEC_READ: err_d = sec_bad;
        default: err_d = sec_bad || locked; // R7 R10
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (taken) state_d = S_WAIT;
      S_WAIT: begin
        if (op_q == FOM_OP_SEC_ERASE && !err_q && !param_q) begin
          state_d = S_ERASE;
        end else begin
          state_d = S_IDLE;
        end
      end
      S_ERASE: if (cnt_q == LAST_IDX) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      ready_o <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_o <= state_d == S_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q <= FOM_OP_ARRAY_READ;
      err_q <= 1'b0;
      param_q <= 1'b0;
      prd_q <= ZERO_B;
      wdata_q <= ZERO_B;
      addr_q <= '0;
      sel_q <= '0;
    end else if (taken) begin
      op_q <= req_i.op;
      err_q <= err_d;
      param_q <= is_param;
      prd_q <= psp_byte(req_i.addr); // R9
      wdata_q <= req_i.wdata;
      addr_q <= req_i.addr;
      sel_q <= sel;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= ZERO_B;
    end else if (state_q == S_ERASE) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      cnt_q <= ZERO_B;
    end
  end

  // ---------------------------------------------------------------
  // lock bits: one-time, cleared only by reset
  // ---------------------------------------------------------------
  // reset empties the copy; the stored bits are merged back next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= '0;
      lock_o <= '0;
    end else begin
      lock_q <= lock_q | lock_nv_i; // R7
      lock_o <= lock_q | lock_nv_i;
      if (state_q == S_WAIT && op_q == FOM_OP_SEC_LOCK && !err_q &&
          !param_q) begin
        lock_q[sel_q-2'd1] <= 1'b1; // R7 R8
        lock_o[sel_q-2'd1] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // security register storage
  // ---------------------------------------------------------------
  always_comb begin
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_addr = {sel, req_i.addr[SREG_BYTE_W-1:0]};
    mem_wdata = ERASED;
    case (state_q)
      S_IDLE: mem_en = taken && fom_is_sec(req_i.op) && !is_param;
      S_WAIT: begin
        mem_en = op_q == FOM_OP_SEC_PROGRAM && !err_q && !param_q;
        mem_we = mem_en;
        mem_addr = {sel_q, addr_q[SREG_BYTE_W-1:0]};
        mem_wdata = mem_rdata & wdata_q; // R1
      end
      S_ERASE: begin
        mem_en = 1'b1;
        mem_we = 1'b1;
        mem_addr = {sel_q, cnt_q}; // R8
      end
      default: mem_en = 1'b0;
    endcase
  end

  fom_otp_mem u_mem (
    .clk_i(clk_i),
    .en_i(mem_en),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // ---------------------------------------------------------------
  // answers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_o <= '0;
    end else begin
      resp_o.done <= 1'b0;
      if (state_q == S_WAIT && state_d == S_IDLE) begin
        resp_o.done <= 1'b1;
        resp_o.err <= err_q;
        if (param_q || (op_q == FOM_OP_SEC_READ && sel_q == '0)) begin
          resp_o.rdata <= prd_q; // R9
        end else if (op_q == FOM_OP_SEC_READ && !err_q) begin
          resp_o.rdata <= mem_rdata;
        end else begin
          resp_o.rdata <= ZERO_B;
        end
      end else if (state_q == S_ERASE && cnt_q == LAST_IDX) begin
        resp_o.done <= 1'b1;
        resp_o.err <= 1'b0;
        resp_o.rdata <= ZERO_B;
      end
    end
  end

  // main array cells live outside; this side issues one decoded strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arr_o <= '0;
    end else begin
      arr_o.go <= 1'b0;
      if (taken && !is_param && !err_d && !fom_is_sec(req_i.op)) begin
        arr_o.go <= 1'b1;
        arr_o.addr <= req_i.addr;
        arr_o.block <= req_i.addr[BLK_LSB+:BLK_W]; // R3
        arr_o.sector <= req_i.addr[SECT_LSB+:SECT_W]; // R4
        arr_o.page <= req_i.addr[PAGE_LSB+:PAGE_W]; // R5
        arr_o.wdata <= req_i.old_data & req_i.wdata; // R1
        case (req_i.op)
          FOM_OP_PROGRAM: arr_o.kind <= FOM_ARR_PROG;
          FOM_OP_ERASE_SECTOR: begin
            arr_o.kind <= FOM_ARR_ERASE_SECTOR;
            arr_o.addr <= {req_i.addr[ADDR_W-1:SECT_LSB],
                           {SECT_LSB{1'b0}}}; // R4
          end
          FOM_OP_ERASE_BLOCK: begin
            arr_o.kind <= FOM_ARR_ERASE_BLOCK;
            arr_o.addr <= {req_i.addr[ADDR_W-1:BLK_LSB],
                           {BLK_LSB{1'b0}}}; // R3
          end
          FOM_OP_ERASE_CHIP: begin
            arr_o.kind <= FOM_ARR_ERASE_CHIP; // R2
            arr_o.addr <= '0;
          end
          default: arr_o.kind <= FOM_ARR_READ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_prog_only_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    arr_o.go && arr_o.kind == FOM_ARR_PROG |->
      (arr_o.wdata & ~$past(req_i.old_data)) == ZERO_B) // R1
    else $error("array program sets a bit");
  a_sreg_prog_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_we && state_q == S_WAIT |-> (mem_wdata & ~mem_rdata) == ZERO_B) // R1
    else $error("register program sets a bit");
  a_page_erase_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    taken && !is_param && req_i.op == FOM_OP_ERASE_PAGE |->
      ##1 !arr_o.go ##1 resp_o.done && resp_o.err) // R2
    else $error("page erase accepted");
  a_block_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    arr_o.go |-> arr_o.block == $past(req_i.addr[20:16]) &&
      arr_o.page == $past(req_i.addr[20:8])) // R3 R5
    else $error("block or page index wrong");
  a_sector_aligned: assert property (@(posedge clk_i) disable iff (rst_i)
    arr_o.go && arr_o.kind == FOM_ARR_ERASE_SECTOR |->
      arr_o.addr[11:0] == 12'h000 &&
      arr_o.addr[23:12] == $past(req_i.addr[23:12])) // R4
    else $error("sector erase base misaligned");
  a_sreg_window: assert property (@(posedge clk_i) disable iff (rst_i)
    taken && !is_param && fom_is_sec(req_i.op) &&
      req_i.addr[11:8] != 4'h0 |-> ##2 resp_o.done && resp_o.err) // R6
    else $error("access outside register window accepted");
  a_lock_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    taken && !is_param && req_i.op == FOM_OP_SEC_PROGRAM && locked |->
      ##1 !mem_we ##1 resp_o.err) // R7
    else $error("locked register modified");
  a_erase_confined: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_ERASE |-> mem_addr[9:8] == sel_q && sel_q != 2'd0) // R8 R10
    else $error("erase strays outside its register");
  a_param_read: assert property (@(posedge clk_i) disable iff (rst_i)
    taken && is_param |-> ##1 !arr_o.go && !mem_we
      ##1 resp_o.done && resp_o.rdata == $past(prd_q)) // R9
    else $error("parameter read misrouted");
  a_param_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_we |-> mem_addr[9:8] != 2'd0) // R10
    else $error("parameter space written");
  a_sig_first: assert property (@(posedge clk_i) disable iff (rst_i)
    taken && is_param && req_i.addr == 24'h00_0000 |->
      ##2 resp_o.rdata == 8'h53) // R11 R15
    else $error("signature byte wrong");
  a_reserved_erased: assert property (@(posedge clk_i) disable iff (rst_i)
    taken && is_param && (req_i.addr[7:0] > 8'h6F ||
      (req_i.addr[7:0] >= 8'h10 && req_i.addr[7:0] < 8'h30)) |->
      ##2 resp_o.rdata == 8'hFF) // R12 R14 R16
    else $error("reserved byte not erased value");

endmodule : fom_space_map

// ==== bench/fom_array_model.sv ====
// array stand-in: byte store behind the array strobe, erased bytes read ff
`timescale 1ns/1ps
module fom_array_model
  import fom_pkg::*;
(
  input wire logic clk_i,
  input wire fom_arr_t arr_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output logic [7:0] old_o
);
  // ---------------------------------------------------------------
  // sparse cell store
  // ---------------------------------------------------------------
  logic [7:0] mem [int];
  int upd;
  int kill [$];
  int sh;

  // an absent key is an erased byte, so erase is just a delete
  always @(addr_i, upd) begin
    old_o = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : ERASED;
  end

  initial upd = 0;

  always @(posedge clk_i) begin
    if (arr_i.go === 1'h1) begin
      sh = (arr_i.kind == FOM_ARR_ERASE_SECTOR) ? 12 : 16;
      case (arr_i.kind)
        FOM_ARR_PROG: mem[int'(arr_i.addr)] = arr_i.wdata;
        FOM_ARR_ERASE_CHIP: mem.delete();
        FOM_ARR_ERASE_SECTOR, FOM_ARR_ERASE_BLOCK: begin
          kill = {};
          foreach (mem[k]) begin
            if ((k >> sh) == (int'(arr_i.addr) >> sh)) kill.push_back(k);
          end
          foreach (kill[j]) mem.delete(kill[j]);
        end
        default: ;
      endcase
      upd++;
    end
  end
endmodule : fom_array_model

// ==== bench/tb_fom_space_map.sv ====
// self-checking bench for the flash space map
`timescale 1ns/1ps
module tb_fom_space_map;
  import fom_pkg::*;
  // ---------------------------------------------------------------
  // harness
  // ---------------------------------------------------------------
  logic clk_i = 1'h0;
  logic rst_i;
  fom_req_t req;
  fom_req_t req_w;
  logic [7:0] old_w;
  logic [2:0] lock_nv;
  logic ready_o;
  fom_resp_t resp_o;
  fom_resp_t got;
  fom_arr_t arr_o;
  fom_arr_t got_arr;
  logic got_go;
  logic [2:0] lock_o;
  int failures = 0;
  int compares = 0;
  logic [23:0] a;
  logic [7:0] w1;
  logic [7:0] w2;
  logic [7:0] sv [1:3];

  always #2.5 clk_i = ~clk_i;

  assign req_w = {req.valid, req.op, req.opcode, req.addr, req.wdata, old_w};

  fom_space_map #(.TBL_P({PSP_TBL_N{8'ha5}})) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_w), .lock_nv_i(lock_nv),
    .ready_o(ready_o), .resp_o(resp_o), .arr_o(arr_o), .lock_o(lock_o)
  );

  fom_array_model i_arr (
    .clk_i(clk_i), .arr_i(arr_o), .addr_i(req.addr), .old_o(old_w)
  );

  // ---------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %0t %s got %0h want %0h", $time, m, g, e);
    end
  endtask : chk

  // one request; waits bounded, keeps the strobe edge and the answer
  task automatic xfer(input fom_op_t op, input logic [7:0] opc,
                      input logic [23:0] ad, input logic [7:0] wd);
    int n;
    n = 0;
    while (ready_o !== 1'h1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 300) begin
      failures++;
      $display("unexpected %0t never ready", $time);
      report_and_stop();
    end
    req.valid = 1'h1;
    req.op = op;
    req.opcode = opc;
    req.addr = ad;
    req.wdata = wd;
    @(negedge clk_i);
    req.valid = 1'h0;
    got_go = 1'h0;
    for (n = 0; n < 300; n++) begin
      if (arr_o.go === 1'h1) begin
        got_go = 1'h1;
        got_arr = arr_o;
      end
      if (resp_o.done === 1'h1) break;
      @(negedge clk_i);
    end
    if (n == 300) begin
      failures++;
      $display("unexpected %0t no answer", $time);
      report_and_stop();
    end
    got = resp_o;
  endtask : xfer

  // fixed bytes of the parameter space as the bench expects them
  function automatic logic [7:0] exp_param(input int i);
    case (i)
      0: return 8'h53;
      1: return 8'h46;
      2: return 8'h44;
      3: return 8'h50;
      default: return (i >= 'h30 && i <= 'h6f) ? 8'ha5 : 8'hff;
    endcase
  endfunction : exp_param

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    req = '0;
    lock_nv = 3'h0;
    rst_i = 1'h1;
    void'($urandom(32'he7ac_2aa9));
    repeat (16) @(negedge clk_i);
    rst_i = 1'h0;

    for (int i = 0; i < 256; i++) begin
      xfer(FOM_OP_ARRAY_READ, CMD_PARAM_READ, {16'h0000, 8'(i)}, 8'h00);
      chk(got.rdata, exp_param(i), "param byte");
      chk(got_go, 1'h0, "param read hit array");
    end
    // opcode wins over a program op: nothing may change
    xfer(FOM_OP_SEC_PROGRAM, CMD_PARAM_READ, 24'h00_0000, 8'h00);
    chk({got.err, got.rdata}, 9'h053, "opcode override");
    $display("test param space done");

    for (int r = 0; r < 20; r++) begin
      a = 24'($urandom) & 24'h1f_ffff;
      w1 = 8'($urandom);
      w2 = (r == 0) ? 8'hff : 8'($urandom);
      xfer(FOM_OP_ERASE_SECTOR, 8'h00, a, 8'h00);
      chk({got_go, got_arr.kind, got_arr.addr},
          {1'h1, FOM_ARR_ERASE_SECTOR, a & 24'h1f_f000}, "sector base");
      chk(got_arr.sector, a[20:12], "sector index");
      xfer(FOM_OP_PROGRAM, 8'h00, a, w1);
      chk({got_go, got_arr.kind, got_arr.wdata},
          {1'h1, FOM_ARR_PROG, w1}, "first program");
      chk(got_arr.page, a[20:8], "page index");
      xfer(FOM_OP_PROGRAM, 8'h00, a, w2);
      chk(got_arr.wdata, w1 & w2, "program sets a bit");
      xfer(FOM_OP_ERASE_BLOCK, 8'h00, a, 8'h00);
      chk({got_go, got_arr.kind, got_arr.addr},
          {1'h1, FOM_ARR_ERASE_BLOCK, a & 24'h1f_0000}, "block base");
      chk(got_arr.block, a[20:16], "block index");
      xfer(FOM_OP_ARRAY_READ, 8'h00, a, 8'h00);
      chk({got.err, got_go, got_arr.kind, got_arr.addr},
          {1'h0, 1'h1, FOM_ARR_READ, a}, "array read");
      xfer(FOM_OP_ERASE_PAGE, 8'h00, a, 8'h00);
      chk({got.err, got_go}, 2'h2, "page erase taken");
      xfer(FOM_OP_PROGRAM, 8'h00, a | 24'h20_0000, 8'h00);
      chk({got.err, got_go}, 2'h2, "address past array");
    end
    xfer(FOM_OP_ERASE_CHIP, 8'h00, 24'h1f_ffff, 8'h00);
    chk({got_arr.kind, got_arr.addr}, {FOM_ARR_ERASE_CHIP, 24'h00_0000},
        "chip erase");
    $display("test array map done");

    for (int n = 1; n < 4; n++) begin
      xfer(FOM_OP_SEC_ERASE, 8'h00, 24'(n) << 12, 8'h00);
      chk(got.err, 1'h0, "register erase");
      sv[n] = 8'($urandom);
      xfer(FOM_OP_SEC_PROGRAM, 8'h00, (24'(n) << 12) | 24'h00_00ff, sv[n]);
      chk(got.err, 1'h0, "register program");
    end
    for (int n = 1; n < 4; n++) begin
      xfer(FOM_OP_SEC_READ, 8'h00, (24'(n) << 12) | 24'h00_00ff, 8'h00);
      chk(got.rdata, sv[n], "register readback");
    end
    xfer(FOM_OP_SEC_READ, 8'h00, 24'h00_1100, 8'h00);
    chk(got.err, 1'h1, "gap address");
    xfer(FOM_OP_SEC_PROGRAM, 8'h00, 24'h00_0040, 8'h00);
    chk(got.err, 1'h1, "param program");
    xfer(FOM_OP_SEC_ERASE, 8'h00, 24'h00_0000, 8'h00);
    chk(got.err, 1'h1, "param erase");
    xfer(FOM_OP_SEC_LOCK, 8'h00, 24'h00_3000, 8'h00);
    chk({got.err, lock_o}, 4'h4, "lock reg3");
    xfer(FOM_OP_SEC_ERASE, 8'h00, 24'h00_3000, 8'h00);
    chk(got.err, 1'h1, "erase locked");
    xfer(FOM_OP_SEC_LOCK, 8'h00, 24'h00_3000, 8'h00);
    chk(got.err, 1'h1, "relock");
    xfer(FOM_OP_SEC_READ, 8'h00, 24'h00_30ff, 8'h00);
    chk(got.rdata, sv[3], "locked content kept");
    lock_nv = 3'h1;
    repeat (3) @(negedge clk_i);
    chk(lock_o, 3'h5, "stored lock bit");
    xfer(FOM_OP_SEC_PROGRAM, 8'h00, 24'h00_10ff, 8'h00);
    chk(got.err, 1'h1, "program locked");
    xfer(FOM_OP_SEC_PROGRAM, 8'h00, 24'h00_20ff, 8'h0f);
    xfer(FOM_OP_SEC_READ, 8'h00, 24'h00_20ff, 8'h00);
    chk(got.rdata, sv[2] & 8'h0f, "open register");
    $display("test security space done");
    // mid-run reset: only the stored lock bit may come back
    rst_i = 1'h1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'h0;
    xfer(FOM_OP_SEC_PROGRAM, 8'h00, 24'h00_10ff, 8'h00);
    chk({got.err, lock_o}, 4'h9, "lock after reset");
    $display("test reset done");
    report_and_stop();
  end
endmodule : tb_fom_space_map
